// ===== hw/ats_sequencer.sv
// Actuator teach-in sequencer of a coded safety gate switch
// Contract
// - Uncoded variant accepts any matching actuator
// - Re-teach variant stores first actuator automatically
// - Single variant stores first, refuses others forever
// - Keep allowance of eight; refuse when used
// - New actuator starts teach, slow yellow blink
// - After twenty seconds present, fast yellow blink
// - Power cycle within 120 s commits
// - Commit stores actuator, allowance minus one
// - Never re-teach any previously stored actuator
`timescale 1ns/1ps
module ats_sequencer
  import ats_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int FAST_CYC = FAST_CYCLES
) (
  // Clock and power-up reset
  input wire logic MCLK,
  input wire logic RST_B,
  // Product variant strap and factory initialisation of the stored image
  input wire logic [1:0] VARIANT,
  input wire logic FACTORY_INIT,
  // Transponder reader
  input wire logic ACT_PRESENT,
  input wire logic ACT_SOLE,
  input wire logic [ID_W-1:0] ACT_ID,
  // Status
  output logic ACCEPTED,
  output logic GATE_LED_YEL,
  output logic TEACH_BUSY,
  output logic TEACH_READY,
  output logic [3:0] REMAIN,
  output logic STORED_VALID,
  output logic [ID_W-1:0] STORED_ID
);

  // Reset synchroniser stages
  logic rst_s1_q;
  logic rst_n;

  // State registers and next values
  ats_vol_t v_q;
  ats_vol_t v_d;
  ats_nv_t nv_q;
  ats_nv_t nv_d;

  // Timebase ticks
  logic fast_tick;
  logic sec_tick;

  // Membership test of an actuator code in the stored history
  function automatic logic ats_seen(input ats_nv_t nv, input logic [ID_W-1:0] id);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < HIST_N; i++) begin
      if ((4'(i) < nv.hist_cnt) && (nv.hist[i] == id)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : ats_seen

  // Append a code to the history and make it the accepted actuator
  function automatic ats_nv_t ats_store(input ats_nv_t nv, input logic [ID_W-1:0] id);
    ats_nv_t r;
    r = nv;
    r.stored_id = id;
    r.stored_valid = 1'b1;
    if (nv.hist_cnt < 4'(HIST_N)) begin
      r.hist[nv.hist_cnt] = id;
      r.hist_cnt = nv.hist_cnt + 4'h1;
    end
    return r;
  endfunction : ats_store

  // Release reset through two flip-flops
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Seconds and blink timebase
  ats_tick #(
    .FAST_CYC(FAST_CYC),
    .FAST_N(SEC_CYC / FAST_CYC)
  ) u_tick (
    .clk(MCLK),
    .rst_n(rst_n),
    .fast_tick(fast_tick),
    .sec_tick(sec_tick)
  );

  // Next-state logic of the sequencer and of the stored image
  always_comb begin
    logic match;
    logic fresh;
    match = ACT_PRESENT && nv_q.stored_valid && (ACT_ID == nv_q.stored_id);
    fresh = 1'b0;
    v_d = v_q;
    nv_d = nv_q;
    v_d.accept = 1'b0;
    case (v_q.st)
      ST_BOOT: begin
        // Catch the strap once reset is released; finish a commit pending at power loss
        v_d.variant = VARIANT;
        v_d.st = ST_IDLE;
        if (nv_q.armed) begin
          nv_d = ats_store(nv_q, nv_q.pend_id);
          nv_d.remain = nv_q.remain - 4'h1;
          nv_d.armed = 1'b0;
        end
      end
      ST_IDLE: begin
        v_d.led = 1'b0;
        v_d.busy = 1'b0;
        v_d.ready = 1'b0;
        v_d.secs = 7'h00;
        if (v_q.variant == VAR_ANY) begin
          // No coding: any matching actuator is accepted on sight
          v_d.accept = ACT_PRESENT;
        end else if (ACT_PRESENT && !nv_q.stored_valid) begin
          // First actuator ever seen is stored at once
          nv_d = ats_store(nv_q, ACT_ID);
          v_d.accept = 1'b1;
        end else if (match) begin
          v_d.accept = 1'b1;
        end else if (ACT_PRESENT && v_q.variant == VAR_RETEACH) begin
          // Only a sole, never-stored actuator with allowance left may start a teach
          fresh = ACT_SOLE && !ats_seen(nv_q, ACT_ID);
          if (fresh && nv_q.remain != 4'h0) begin
            v_d.st = ST_SLOW;
            v_d.cand = ACT_ID;
            v_d.busy = 1'b1;
          end
        end
        // Single variant: any other actuator simply stays refused
      end
      ST_SLOW: begin
        if (!ACT_PRESENT || ACT_ID != v_q.cand || !ACT_SOLE) begin
          // Actuator left: drop the attempt, image untouched
          v_d.st = ST_IDLE;
          v_d.busy = 1'b0;
          v_d.led = 1'b0;
        end else if (sec_tick) begin
          v_d.led = !v_q.led;
          if (v_q.secs == TEACH_S - 7'h01) begin
            // Present long enough: open the commit window
            v_d.st = ST_FAST;
            v_d.secs = 7'h00;
            v_d.ready = 1'b1;
            nv_d.armed = 1'b1;
            nv_d.pend_id = v_q.cand;
          end else begin
            v_d.secs = v_q.secs + 7'h01;
          end
        end
      end
      ST_FAST: begin
        if (!ACT_PRESENT || ACT_ID != v_q.cand) begin
          // Removal during the window cancels the commit
          v_d.st = ST_IDLE;
          v_d.busy = 1'b0;
          v_d.led = 1'b0;
          v_d.ready = 1'b0;
          nv_d.armed = 1'b0;
        end else begin
          if (fast_tick) begin
            v_d.led = !v_q.led;
          end
          if (sec_tick) begin
            if (v_q.secs == COMMIT_S - 7'h01) begin
              // Window expired without a power cycle
              v_d.st = ST_IDLE;
              v_d.busy = 1'b0;
              v_d.led = 1'b0;
              v_d.ready = 1'b0;
              nv_d.armed = 1'b0;
            end else begin
              v_d.secs = v_q.secs + 7'h01;
            end
          end
        end
      end
      default: begin
        v_d.st = ST_IDLE;
      end
    endcase
    // Factory initialisation wipes the stored image
    if (FACTORY_INIT) begin
      nv_d = '0;
      nv_d.remain = TEACH_MAX;
    end
  end

  // Volatile state, cleared at every power-up
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      v_q <= '{st: ST_BOOT, default: '0};
    end else begin
      v_q <= v_d;
    end
  end

  // Stored image has no reset so that it outlives a power cycle
  always_ff @(posedge MCLK) begin
    nv_q <= nv_d;
  end

  // Outputs straight from flip-flops
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ACCEPTED <= 1'b0;
      GATE_LED_YEL <= 1'b0;
      TEACH_BUSY <= 1'b0;
      TEACH_READY <= 1'b0;
      REMAIN <= 4'h0;
      STORED_VALID <= 1'b0;
      STORED_ID <= '0;
    end else begin
      ACCEPTED <= v_d.accept;
      GATE_LED_YEL <= v_d.led;
      TEACH_BUSY <= v_d.busy;
      TEACH_READY <= v_d.ready;
      REMAIN <= nv_d.remain;
      STORED_VALID <= nv_d.stored_valid;
      STORED_ID <= nv_d.stored_id;
    end
  end

endmodule : ats_sequencer

// ===== include/ats_pkg.sv
// Package of constants and types for the actuator teach-in sequencer
package ats_pkg;

  // Clock rate and derived timebase
  localparam int CLK_HZ = 50_000_000;       // MCLK rate in Hz
  localparam int SEC_CYCLES = CLK_HZ * 1;   // Cycles in one second
  localparam int FAST_PER_S = 8;            // Fast blink half-periods per second
  localparam int FAST_CYCLES = SEC_CYCLES / FAST_PER_S;

  // Teach timing in seconds
  localparam logic [6:0] TEACH_S = 7'h14;   // Presence before commit is ready (20 s)
  localparam logic [6:0] COMMIT_S = 7'h78;  // Commit window length (120 s)

  // Allowance and history
  localparam logic [3:0] TEACH_MAX = 4'h8;  // Re-teach allowance after factory init
  localparam int HIST_N = 9;                // First actuator plus eight re-teaches
  localparam int ID_W = 16;                 // Actuator code width

  // Variant strap encodings
  localparam logic [1:0] VAR_ANY = 2'h0;    // Any matching actuator
  localparam logic [1:0] VAR_RETEACH = 2'h1;// First actuator plus re-teaches
  localparam logic [1:0] VAR_ONCE = 2'h2;   // First actuator only

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_SLOW = 4'h4,
    ST_FAST = 4'h8
  } ats_state_t;

  // Non-volatile image: survives power cycles
  typedef struct packed {
    logic [HIST_N-1:0][ID_W-1:0] hist;  // Every actuator ever stored
    logic [3:0] hist_cnt;               // Valid history entries
    logic [ID_W-1:0] stored_id;         // Accepted actuator
    logic stored_valid;                 // An actuator has been stored
    logic [3:0] remain;                 // Remaining teach procedures
    logic armed;                        // Commit window open at power loss
    logic [ID_W-1:0] pend_id;           // Actuator waiting for commit
  } ats_nv_t;

  // Volatile state, cleared by reset
  typedef struct packed {
    ats_state_t st;          // Sequencer state
    logic [1:0] variant;     // Strap captured after reset release
    logic [6:0] secs;        // Seconds in current phase
    logic [ID_W-1:0] cand;   // Candidate actuator
    logic led;               // Yellow indicator drive
    logic accept;            // Actuator accepted
    logic busy;              // Teach attempt running
    logic ready;             // Teach ready to commit
  } ats_vol_t;

endpackage : ats_pkg

// ===== hw/ats_tick.sv
// Timebase: fast blink tick and one-second tick from MCLK
`timescale 1ns/1ps
module ats_tick #(
  parameter int FAST_CYC = ats_pkg::FAST_CYCLES,
  parameter int FAST_N = ats_pkg::FAST_PER_S
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ticks
  output logic fast_tick,
  output logic sec_tick
);

  logic [31:0] div_q;  // Cycle divider
  logic [7:0] sub_q;   // Fast ticks within the second

  // Divide the clock down to fast ticks, and fast ticks down to seconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
      sub_q <= 8'h00;
      fast_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      fast_tick <= 1'b0;
      sec_tick <= 1'b0;
      if (div_q == 32'(FAST_CYC - 1)) begin
        // End of a fast period
        div_q <= 32'h0000_0000;
        fast_tick <= 1'b1;
        if (sub_q == 8'(FAST_N - 1)) begin
          sub_q <= 8'h00;
          sec_tick <= 1'b1;
        end else begin
          sub_q <= sub_q + 8'h01;
        end
      end else begin
        div_q <= div_q + 32'h0000_0001;
      end
    end
  end

endmodule : ats_tick

// ===== verification/ats_tag_model.sv
// Coded actuator transponder model at the reader
`timescale 1ns/1ps
module ats_tag_model
  import ats_pkg::*;
(
  // Bench control
  input wire logic clk,
  input wire logic on,
  input wire logic sole,
  input wire logic [ID_W-1:0] id,
  // Reader side
  output logic present = 1'b0,
  output logic only = 1'b0,
  output logic [ID_W-1:0] code = 16'h0000
);
  // Out of range the code line flips each cycle, never a stale code
  always @(posedge clk) begin
    present <= on;
    only <= on & sole;
    code <= on ? id : ~code;
  end
endmodule : ats_tag_model

// ===== verification/ats_sequencer_chk.sv
// Port checker of the teach-in sequencer
`timescale 1ns/1ps
module ats_sequencer_chk
  import ats_pkg::*;
(
  // Clock, reset and inputs
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [1:0] VARIANT,
  input wire logic FACTORY_INIT,
  input wire logic ACT_PRESENT,
  input wire logic ACT_SOLE,
  // Status
  input wire logic ACCEPTED,
  input wire logic GATE_LED_YEL,
  input wire logic TEACH_BUSY,
  input wire logic TEACH_READY,
  input wire logic [3:0] REMAIN,
  input wire logic STORED_VALID,
  input wire logic [ID_W-1:0] STORED_ID
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Image outputs settled and no wipe in flight
  logic quiet;
  assign quiet = STORED_VALID && !FACTORY_INIT;
  led_idle_a: assert property (!TEACH_BUSY |-> !GATE_LED_YEL) else $error("led lit while idle");
  ready_busy_a: assert property (TEACH_READY |-> TEACH_BUSY) else $error("ready outside teach");
  remain_max_a: assert property (REMAIN <= TEACH_MAX) else $error("allowance too big");
  spent_a: assert property (REMAIN == 4'h0 && STORED_VALID && !TEACH_BUSY |=> !TEACH_BUSY)
    else $error("teach with no allowance");
  leave_a: assert property (TEACH_BUSY && !ACT_PRESENT |=> !TEACH_BUSY) else $error("teach kept");
  sole_a: assert property (!TEACH_BUSY && !ACT_SOLE |=> !TEACH_BUSY) else $error("teach not sole");
  id_hold_a: assert property (quiet && $past(quiet) |=> $stable(STORED_ID) || !STORED_VALID)
    else $error("stored code moved");
  cnt_hold_a: assert property (quiet && $past(quiet) |=> $stable(REMAIN) || !STORED_VALID)
    else $error("allowance moved");
  any_acc_a: assert property (VARIANT == VAR_ANY && ACT_PRESENT && $past(ACT_PRESENT) |=> ACCEPTED)
    else $error("any actuator refused");
endmodule : ats_sequencer_chk
bind ats_sequencer ats_sequencer_chk u_chk (.MCLK(MCLK), .RST_B(RST_B), .VARIANT(VARIANT),
  .FACTORY_INIT(FACTORY_INIT), .ACT_PRESENT(ACT_PRESENT), .ACT_SOLE(ACT_SOLE), .ACCEPTED(ACCEPTED),
  .GATE_LED_YEL(GATE_LED_YEL), .TEACH_BUSY(TEACH_BUSY), .TEACH_READY(TEACH_READY), .REMAIN(REMAIN),
  .STORED_VALID(STORED_VALID), .STORED_ID(STORED_ID));

// ===== verification/ats_sequencer_test.sv
// Self-checking bench of the teach-in sequencer
`timescale 1ns/1ps
module ats_sequencer_test
  import ats_pkg::*;
;
  localparam int SC = 80; // Shortened second
  logic mclk = 1'b0, rst_b = 1'b0, init = 1'b0, on = 1'b0, sole = 1'b1;
  logic [1:0] var_s = VAR_RETEACH;
  logic [15:0] id = 16'h0000, code, sid;
  logic pres, only, acc, led, busy, rdy, sv;
  logic [3:0] rem;
  int failures = 0, tests_run = 0, cyc = 0, t;
  // Clock and cycle ceiling
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  initial begin
    wait (cyc == 60000);
    failures++;
    finish_test();
  end
  ats_tag_model u_tag (.clk(mclk), .on(on), .sole(sole), .id(id), .present(pres), .only(only), .code(code));
  ats_sequencer #(.SEC_CYC(SC), .FAST_CYC(SC / 8)) u_dut (.MCLK(mclk), .RST_B(rst_b), .VARIANT(var_s),
    .FACTORY_INIT(init), .ACT_PRESENT(pres), .ACT_SOLE(only), .ACT_ID(code), .ACCEPTED(acc),
    .GATE_LED_YEL(led), .TEACH_BUSY(busy), .TEACH_READY(rdy), .REMAIN(rem), .STORED_VALID(sv), .STORED_ID(sid));
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Wait cycles, then settle past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task automatic put(input logic [15:0] i, input logic s);
    @(posedge mclk) id <= i;
    sole <= s;
    on <= 1'b1;
    wt(4);
  endtask : put
  task automatic rm();
    @(posedge mclk) on <= 1'b0;
    wt(4);
  endtask : rm
  // Power cycle; an optional image wipe is held inside reset so no unknown image is ever shown
  task automatic power(input logic [1:0] v, input logic fi);
    @(posedge mclk) rst_b <= 1'b0;
    var_s <= v;
    init <= fi;
    wt(8);
    @(posedge mclk) rst_b <= 1'b1;
    init <= 1'b0;
    wt(6);
  endtask : power
  // Count indicator toggles
  task automatic tog(input int n);
    logic p;
    t = 0;
    p = led;
    repeat (n) begin
      wt(1);
      if (led !== p) t++;
      p = led;
    end
  endtask : tog
  // Full teach and commit by power cycle
  task automatic teach(input logic [15:0] i);
    put(i, 1'b1);
    wt(SC * 18);
    chk("early", 0, rdy);
    wt(SC * 3);
    chk("ready", 1, rdy);
    tog(SC);
    chk("fast", 1, t >= 7 && t <= 9);
    power(VAR_RETEACH, 1'b0);
    chk("taught", i, sid);
    rm();
  endtask : teach
  task automatic t_once();
    power(VAR_ONCE, 1'b1);
    put(16'h00a1, 1'b1);
    chk("once", 16'h00a1, sid);
    rm();
    put(16'h00b2, 1'b1);
    wt(SC * 2);
    chk("once busy", 0, busy);
    chk("once acc", 0, acc);
    chk("once id", 16'h00a1, sid);
    rm();
  endtask : t_once
  task automatic t_any();
    power(VAR_ANY, 1'b1);
    put(16'h00c3, 1'b1);
    chk("any acc", 1, acc);
    chk("any store", 0, sv);
    rm();
  endtask : t_any
  task automatic t_abort();
    power(VAR_RETEACH, 1'b1);
    chk("init", 8, rem);
    put(16'h00a1, 1'b1);
    chk("first", 16'h00a1, sid);
    rm();
    put(16'h00b2, 1'b1);
    chk("busy", 1, busy);
    tog(SC * 3);
    chk("slow", 1, t >= 2 && t <= 4);
    rm();
    chk("abandon", 0, busy);
    chk("kept", 16'h00a1, sid);
  endtask : t_abort
  task automatic t_window();
    put(16'h00e5, 1'b1);
    wt(SC * 22);
    chk("win rdy", 1, rdy);
    wt(SC * 121);
    chk("expired", 0, rdy);
    power(VAR_RETEACH, 1'b0);
    chk("win id", 16'h00b2, sid);
    chk("win cnt", 7, rem);
    rm();
  endtask : t_window
  task automatic t_refuse(input logic [15:0] i, input logic s);
    put(i, s);
    chk("refuse", 0, busy);
    rm();
  endtask : t_refuse
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    t_once();
    t_any();
    t_abort();
    teach(16'h00b2);
    chk("count", 7, rem);
    t_refuse(16'h00a1, 1'b1);
    t_refuse(16'h00d4, 1'b0);
    t_window();
    for (int k = 0; k < 7; k++) begin
      teach(16'h0100 + 16'(k));
      chk("count", 16'(6 - k), rem);
    end
    t_refuse(16'h00f6, 1'b1);
    finish_test();
  end
endmodule : ats_sequencer_test
